/* File: design/call_pkg.sv */
package call_pkg;
	// argument and result widths of the example component
	localparam int DATA_W   = 32;
	localparam int ADDR_W   = 32;
	localparam int INDEX_W  = 32;
	// latency of the fixed arithmetic stage in cycles
	localparam int MUL_LAT  = 2;
	// result queue depth, one more than the pipeline can hold
	localparam int QDEPTH   = 4;
	localparam int QPTR_W   = 2;
	localparam logic [QPTR_W:0] QCOUNT_RST = 3'h0;
	localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;

	typedef enum logic [1:0] {
		mem_idle,
		mem_wait
	} mem_state_t;
endpackage : call_pkg

/* File: design/mem_if.sv */
`timescale 1ns/1ps
// word request from the core to the shared memory port
interface mem_if;
	import call_pkg::*;
	logic              req;
	logic [ADDR_W-1:0] addr;
	logic              gnt;
	logic              rvalid;
	logic [DATA_W-1:0] rdata;
	modport core (output req, output addr, input gnt, input rvalid,
		input rdata);
	modport port (input req, input addr, output gnt, output rvalid,
		output rdata);
endinterface : mem_if

/* File: design/mem_master.sv */
`timescale 1ns/1ps
// **********************************************
// shared memory master port, one read in flight
// **********************************************
module mem_master
	import call_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rst,
	mem_if.port                    core,
	output logic                   rd,
	output logic [ADDR_W-1:0]      address,
	input  wire logic              waitreq,
	input  wire logic              rd_valid,
	input  wire logic [DATA_W-1:0] rd_data
);
	mem_state_t state_q;

	// read command is held until the slave drops waitreq
	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= mem_idle;
			rd      <= 1'b0;
			address <= '0;
		end else begin
			unique case (state_q)
				mem_idle: begin
					if (core.req && !rd) begin
						rd      <= 1'b1;
						address <= core.addr;
					end else if (rd && !waitreq) begin
						rd      <= 1'b0;
						state_q <= mem_wait;
					end
				end
				mem_wait: begin
					if (rd_valid) begin
						state_q <= mem_idle;
					end
				end
				default: state_q <= mem_idle;
			endcase
		end
	end

	assign core.gnt    = rd && !waitreq;
	assign core.rvalid = (state_q == mem_wait) && rd_valid;
	assign core.rdata  = rd_data;
endmodule : mem_master

/* File: design/call_component.sv */
`timescale 1ns/1ps
module call_component
	import call_pkg::*;
(
	input  wire logic               clock,
	input  wire logic               rst,
	input  wire logic               start,
	output logic                    busy,
	input  wire logic [DATA_W-1:0]  arg_a,
	input  wire logic [ADDR_W-1:0]  arg_b_base,
	input  wire logic [INDEX_W-1:0] arg_i,
	output logic                    done,
	input  wire logic               stall,
	output logic [DATA_W-1:0]       result,
	output logic                    mem_read,
	output logic [ADDR_W-1:0]       mem_address,
	input  wire logic               mem_waitrequest,
	input  wire logic               mem_readdatavalid,
	input  wire logic [DATA_W-1:0]  mem_readdata
);
	// ************************************************
	// helpers
	// ************************************************
	// one flag widened to the queue count, so sums keep their width
	function automatic logic [QPTR_W:0] widen(input logic flag);
		widen = {{QPTR_W{1'b0}}, flag};
	endfunction : widen

	// ************************************************
	// call side
	// ************************************************
	// word request toward the shared master; one owner per signal
	mem_if mem ();

	logic              take;
	logic              fetch_q;
	logic [DATA_W-1:0] a_q;
	logic [ADDR_W-1:0] addr_q;
	logic              stage_busy;

	// one element fetch may be open; busy covers it and a full queue
	assign take = start && !busy;

	// arguments latched only on the call handshake
	// addr_q keeps its old value between calls; only a take moves it
	always_ff @(posedge clock) begin
		if (rst) begin
			a_q    <= DATA_RST;
			addr_q <= '0;
		end else if (take) begin
			a_q    <= arg_a;
			// byte address of b[i], word sized elements
			addr_q <= arg_b_base + ADDR_W'(arg_i << 2);
		end
	end

	// fetch request pending toward the shared master
	// a take and a grant never meet: busy is high while fetch_q is
	always_ff @(posedge clock) begin
		if (rst) begin
			fetch_q <= 1'b0;
		end else if (take) begin
			fetch_q <= 1'b1;
		end else if (mem.gnt) begin
			fetch_q <= 1'b0;
		end
	end

	// request and address stay put until the grant
	assign mem.req  = fetch_q;
	assign mem.addr = addr_q;

	// all pointer reads leave through this one port
	mem_master u_mem (
		.clock    (clock),
		.rst      (rst),
		.core     (mem),
		.rd       (mem_read),
		.address  (mem_address),
		.waitreq  (mem_waitrequest),
		.rd_valid (mem_readdatavalid),
		.rd_data  (mem_readdata)
	);

	// ************************************************
	// fixed latency multiply pipeline
	// ************************************************
	logic               wait_q;
	logic [DATA_W-1:0]  held_a_q;
	logic [MUL_LAT-1:0] vld_q;
	logic [DATA_W-1:0]  prod_q [MUL_LAT];

	// operand a kept until its memory word returns
	// a grant and a return cannot meet: only one read is ever open
	always_ff @(posedge clock) begin
		if (rst) begin
			wait_q   <= 1'b0;
			held_a_q <= DATA_RST;
		end else if (mem.gnt) begin
			wait_q   <= 1'b1;
			held_a_q <= a_q;
		end else if (mem.rvalid) begin
			wait_q   <= 1'b0;
		end
	end

	// stages never stall; the queue reserves room for all in flight
	always_ff @(posedge clock) begin
		if (rst) begin
			vld_q <= '0;
		end else begin
			vld_q <= {vld_q[MUL_LAT-2:0], mem.rvalid};
		end
	end

	// product data carries no reset; only vld_q says it is meaningful
	always_ff @(posedge clock) begin
		prod_q[0] <= held_a_q * mem.rdata;
	end

	// later stages only delay the product, in step with vld_q
	genvar s;
	generate
		for (s = 1; s < MUL_LAT; s++) begin : g_stage
			always_ff @(posedge clock) begin
				prod_q[s] <= prod_q[s-1];
			end
		end
	endgenerate

	// ************************************************
	// return side
	// ************************************************
	logic [DATA_W-1:0] q_mem [QDEPTH];
	logic [QPTR_W-1:0] wr_q;
	logic [QPTR_W-1:0] rd_q;
	logic [QPTR_W:0]   cnt_q;
	logic              push;
	logic              pop;
	logic [QPTR_W:0]   in_flight;

	// a product leaves the pipeline into the queue; the head leaves
	// only on an edge where the consumer takes it
	assign push = vld_q[MUL_LAT-1];
	assign pop  = done && !stall;

	// calls already taken but not yet in the queue
	assign in_flight = widen(fetch_q) + widen(wait_q)
		+ (QPTR_W+1)'($countones(vld_q));
	// the fetch stage holds one call at a time, so it blocks the next
	assign stage_busy = fetch_q || wait_q;

	// results written in arrival order, which is call order
	always_ff @(posedge clock) begin
		if (push) begin
			q_mem[wr_q] <= prod_q[MUL_LAT-1];
		end
	end

	// queue pointers wrap at the depth; the count keeps the extra bit
	always_ff @(posedge clock) begin
		if (rst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= QCOUNT_RST;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			// push and pop in one edge leave the count unchanged
			cnt_q <= cnt_q + widen(push) - widen(pop);
		end
	end

	// done and result registered; held while stalled
	always_ff @(posedge clock) begin
		if (rst) begin
			done   <= 1'b0;
			result <= DATA_RST;
		end else if (!done || !stall) begin
			// the entry behind the head shows at once when it is taken
			if (cnt_q - widen(pop) != '0) begin
				done   <= 1'b1;
				result <= q_mem[pop ? rd_q + 1'b1 : rd_q];
			// empty queue: a new product goes straight out, saving a cycle
			end else if (push) begin
				done   <= 1'b1;
				result <= prod_q[MUL_LAT-1];
			end else begin
				done   <= 1'b0;
			end
		end
	end

	// limitation: one fetch at a time caps the call rate
	// busy: fetch stage occupied next cycle or queue could overflow
	always_ff @(posedge clock) begin
		if (rst) begin
			busy <= 1'b1;
		end else begin
			// busy is a flop, so the call taken now is counted as well
			busy <= stage_busy || take
				|| (cnt_q + in_flight + widen(take)
				>= (QPTR_W+1)'(QDEPTH - 1));
		end
	end
endmodule : call_component

/* File: tb/mem_model.sv */
`timescale 1ns/1ps
// ****
// system memory behind the shared port
// ****
module mem_model (
	input  logic        clock,
	input  logic        rst,
	input  logic [1:0]  slow,
	input  logic        mem_read,
	input  logic [31:0] mem_address,
	output logic        mem_waitrequest,
	output logic        mem_readdatavalid,
	output logic [31:0] mem_readdata
);
	logic [1:0]  wait_q;
	logic [31:0] word_q;
	// stall acceptance for slow cycles, word made from its address
	always_ff @(posedge clock) begin
		wait_q <= mem_waitrequest ? wait_q + 2'h1 : 2'h0;
		mem_readdatavalid <= !rst && mem_read && !mem_waitrequest;
		if (mem_read && !mem_waitrequest)
			word_q <= mem_address ^ 32'hC3C3_0000;
	end
	assign mem_waitrequest = mem_read && wait_q != slow;
	// junk between beats, so a stale word never passes
	assign mem_readdata = mem_readdatavalid ? word_q : ~word_q;
endmodule : mem_model

/* File: tb/call_component_assertions.sv */
`timescale 1ns/1ps
// ****
// call port checks
// ****
module call_component_assertions (
	input logic        clock,
	input logic        rst,
	input logic        start,
	input logic        busy,
	input logic        done,
	input logic        stall,
	input logic [31:0] result,
	input logic        mem_read,
	input logic        mem_waitrequest,
	input logic        mem_readdatavalid
);
	logic [2:0] pend_q;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_take; start && !busy; endsequence
	sequence s_beat; mem_read && !mem_waitrequest; endsequence
	// calls in flight; a result with no call shows here
	always_ff @(posedge clock)
		pend_q <= rst ? 3'h0 : pend_q + 3'(start && !busy)
			- 3'(done && !stall);
	a_reset_idle: assert property (disable iff (1'b0)
		rst |=> busy && !done) else $error("not idle");
	a_take_fetch: assert property (s_take |=> busy ##1 mem_read)
		else $error("no fetch");
	a_one_read: assert property (s_beat |=> !mem_read)
		else $error("second read");
	a_read_hold: assert property (mem_read && mem_waitrequest
		|=> mem_read) else $error("read dropped");
	a_done_lat: assert property (mem_readdatavalid |-> ##3 done)
		else $error("late done");
	a_stall_hold: assert property (done && stall
		|=> done && $stable(result)) else $error("stall");
	a_no_phantom: assert property (done |-> pend_q != 3'h0)
		else $error("stray done");
	a_pend_cap: assert property (pend_q <= 3'h4)
		else $error("overfull");
endmodule : call_component_assertions
bind call_component call_component_assertions u_chk (
	.clock             (clock),
	.rst               (rst),
	.start             (start),
	.busy              (busy),
	.done              (done),
	.stall             (stall),
	.result            (result),
	.mem_read          (mem_read),
	.mem_waitrequest   (mem_waitrequest),
	.mem_readdatavalid (mem_readdatavalid)
);

/* File: tb/call_component_tb.sv */
`timescale 1ns/1ps
// ****
// call port bench
// ****
module call_component_tb;
	logic        clock = 1'b0, rst = 1'b1, start = 1'b0, stall = 1'b0;
	logic [1:0]  slow = 2'h0;
	logic [31:0] arg_a = 32'h0, arg_b_base = 32'h0, arg_i = 32'h0;
	logic        busy, done, mem_read, mem_waitrequest, mem_readdatavalid;
	logic [31:0] result, mem_readdata, mem_address;
	logic [31:0] exp_q[$];
	int          error_cnt = 0;
	int          n_checks = 0;
	call_component u_dut (
		.clock             (clock),
		.rst               (rst),
		.start             (start),
		.busy              (busy),
		.arg_a             (arg_a),
		.arg_b_base        (arg_b_base),
		.arg_i             (arg_i),
		.done              (done),
		.stall             (stall),
		.result            (result),
		.mem_read          (mem_read),
		.mem_address       (mem_address),
		.mem_waitrequest   (mem_waitrequest),
		.mem_readdatavalid (mem_readdatavalid),
		.mem_readdata      (mem_readdata)
	);
	mem_model u_mem (
		.clock             (clock),
		.rst               (rst),
		.slow              (slow),
		.mem_read          (mem_read),
		.mem_address       (mem_address),
		.mem_waitrequest   (mem_waitrequest),
		.mem_readdatavalid (mem_readdatavalid),
		.mem_readdata      (mem_readdata)
	);
	always #4 clock = ~clock;
	function automatic void miss(input string m);
		error_cnt++;
		$display("MISMATCH %0t %s", $time, m);
	endfunction : miss
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	// consumer: each taken result against the oldest call
	always @(posedge clock)
		if (!rst && done === 1'b1 && stall === 1'b0) begin
			n_checks++;
			if (exp_q.size() == 0) miss("stray");
			else if (result !== exp_q.pop_front()) miss("data");
		end
	// start and arguments held until an edge sees busy low
	task automatic call(input logic [31:0] a, b, i);
		int n;
		@(posedge clock);
		start <= 1'b1;
		arg_a <= a;
		arg_b_base <= b;
		arg_i <= i;
		for (n = 0; n < 40; n++) begin
			@(posedge clock);
			if (busy === 1'b0) break;
		end
		if (n == 40) begin
			miss("no take");
			wrap_up();
		end
		exp_q.push_back(a * ((b + (i << 2)) ^ 32'hC3C3_0000));
		start <= 1'b0;
	endtask : call
	task automatic drain();
		repeat (200) if (exp_q.size() != 0) @(posedge clock);
		if (exp_q.size() != 0) begin
			miss("no result");
			wrap_up();
		end
	endtask : drain
	task automatic t_single();
		call(32'h5, 32'h100, 32'h3);
		drain();
		@(posedge clock);
		n_checks++;
		if (done !== 1'b0) miss("done stuck");
		$display("single end");
	endtask : t_single
	// three calls pile up behind a stalled consumer
	task automatic t_stall();
		stall <= 1'b1;
		call(32'h7, 32'h200, 32'h0);
		call(32'hFFFF_FFFF, 32'h200, 32'h1);
		call(32'h3, 32'h204, 32'h2);
		repeat (20) @(posedge clock);
		n_checks++;
		if (done !== 1'b1) miss("done lost");
		stall <= 1'b0;
		drain();
		$display("stall end");
	endtask : t_stall
	task automatic t_slow();
		slow <= 2'h3;
		call(32'h9, 32'hFFFF_FFF0, 32'h3FFF_FFFF);
		drain();
		slow <= 2'h0;
		$display("slow end");
	endtask : t_slow
	// reset while a call is in flight, then run again
	task automatic t_reset();
		call(32'h2, 32'h300, 32'h5);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		n_checks++;
		if (busy !== 1'b1 || done !== 1'b0) miss("reset");
		exp_q.delete();
		rst <= 1'b0;
		call(32'h4, 32'h300, 32'h6);
		drain();
		$display("reset end");
	endtask : t_reset
	initial begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		t_single();
		t_stall();
		t_slow();
		t_reset();
		wrap_up();
	end
endmodule : call_component_tb
